// file: common/stct_defines.svh
// Register offsets, field positions and timing constants for the class and protocol timers
`ifndef STCT_DEFINES_SVH
`define STCT_DEFINES_SVH
`define STCT_OFF_CLASS      4'h0
`define STCT_OFF_TXTIME     4'h4
`define STCT_OFF_PTIMER     4'h8
`define STCT_OFF_STATUS     4'hC
`define STCT_RST_CLASS      16'h0000
`define STCT_RST_TXTIME     32'h0000_0000
`define STCT_RST_PTIMER     16'h0000
`define STCT_CNT_HI         15
`define STCT_CNT_LO         12
`define STCT_PRE_HI         11
`define STCT_PRE_LO         8
`define STCT_CON_HI         7
`define STCT_CON_LO         0
`define STCT_CONN_TICK_BIT  5
`endif

// file: common/stct_pkg.sv
// Types for the class and protocol timers
package stct_pkg;
   typedef enum logic [1:0] {
      STCT_FIRST_SLOT_SETTING   = 2'h0,
      STCT_SECOND_SLOT_SETTING   = 2'h1,
      STCT_FIRST_RANDOM_SETTING = 2'h2,
      STCT_SECOND_RANDOM_SETTING = 2'h3
   } stct_class_t;
   typedef enum logic [2:0] {
      STCT_NONE     = 3'h0,
      STCT_REJECT_TIMEOUT_ERROR   = 3'h1,
      STCT_CONNECTION_TIMEOUT_ERROR  = 3'h2,
      STCT_WAIT_TIMEOUT_ERROR  = 3'h3
   } stct_err_t;
   typedef enum logic [1:0] {
      STCT_IDLE    = 2'b00,
      STCT_BIDDING = 2'b01,
      STCT_WAITACK = 2'b11,
      STCT_LOCKED  = 2'b10
   } stct_state_t;
endpackage : stct_pkg

// file: rtl/stct_top.sv
// Message classification and switch transmit protocol timers
//
// Summary of operation
// - Sixteen-bit class lookup register holds eight two-bit class fields.
// - Index is lock bit then request type; 000 picks lowest field.
// - Class 00/01 pick slot settings, 10/11 pick random settings.
// - Class 10 takes start and retry criteria from first random setting.
// - Thirty-two-bit timing register: second_random_setting, first_random_setting, second_slot_setting, first_slot_setting from top.
// - Synchronous request forces class 00 and first slot setting.
// - Reject timer is enabled at first attempt of each initial message.
// - While bidding, or awaiting acknowledge with no connection underflow, reject with latched reject underflow aborts, reports reject timeout, tears down.
// - Reject timer is a 4-bit down-counter reloaded from count field.
// - Reject tick on rising edge of rtc low-word bit chosen by prescale.
// - Reject timer reloads every cycle until first bid starts.
// - Reject timeout is count plus one, times two to prescale plus one, microseconds.
// - Connection timer reloads at each first bid; underflow is latched.
// - Connection underflow awaiting acknowledge tears down, reports connection timeout.
// - Connection underflow on locked path after acknowledge tears down, reports wait timeout at next request.
// - Acknowledge and underflow together count as connection timeout.
// - Connection timer is 8-bit, ticks from prescaler bit 5, reloads from field.
// - Connection timeout is field plus one microseconds.
// - Protocol register: count 15:12, prescale 11:8, connection reload 7:0.
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "stct_defines.svh"
module stct_top
   import stct_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [1:0]  avs_response,
   input  wire logic [15:0] rtc_low_word,
   input  wire logic [5:0]  prescaler,
   input  wire logic        req_valid,
   input  wire logic        lock_operation_bit,
   input  wire logic [1:0]  request_type_bits,
   input  wire logic        sync_request,
   input  wire logic        first_bid,
   input  wire logic        switch_reject,
   input  wire logic        msg_ack,
   input  wire logic        path_locked,
   output logic      [1:0]  class_code_q,
   output logic      [7:0]  start_setting_q,
   output logic      [7:0]  retry_setting_q,
   output logic             teardown_q,
   output logic      [2:0]  error_code_q,
   output logic             error_valid_q
);
   logic [15:0] class_lookup_q;
   logic [31:0] tx_timing_q;
   logic [15:0] ptimer_q;
   logic        rd_done_q;
   logic [3:0]  rej_cnt_q;
   logic        rej_unf_q;
   logic [7:0]  conn_cnt_q;
   logic        conn_unf_q;
   logic [15:0] rtc_s1_q;
   logic [15:0] rtc_s2_q;
   logic [5:0]  pre_s1_q;
   logic [5:0]  pre_s2_q;
   logic        rej_bit_q;
   logic        conn_bit_q;
   logic        wait_pend_q;
   stct_state_t state_q;
   logic [2:0]  class_idx;
   logic [1:0]  class_sel;
   logic        rej_bit;
   logic        rej_tick;
   logic        conn_tick;
   logic        rej_run;
   logic        conn_unf_now;
   logic        wr_en;
   logic        rd_en;
   logic [31:0] class_merged;
   logic [31:0] ptimer_merged;

   assign wr_en = clk_en && avs_write;
   assign rd_en = clk_en && avs_read && !rd_done_q;

   // Writes finish at once; reads wait one cycle; everything waits while disabled
   assign avs_waitrequest = clk_en ? (avs_read && !rd_done_q) : (avs_read || avs_write);
   assign avs_response    = 2'h0;

   function automatic logic [31:0] stct_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : stct_merge

   assign class_merged  = stct_merge({16'h0000, class_lookup_q}, avs_writedata, avs_byteenable);
   assign ptimer_merged = stct_merge({16'h0000, ptimer_q}, avs_writedata, avs_byteenable);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         class_lookup_q <= `STCT_RST_CLASS;
         tx_timing_q    <= `STCT_RST_TXTIME;
         ptimer_q       <= `STCT_RST_PTIMER;
      end else if (wr_en) begin
         case (avs_address)
            `STCT_OFF_CLASS: begin
               class_lookup_q <= class_merged[15:0];
            end
            `STCT_OFF_TXTIME: begin
               tx_timing_q <= stct_merge(tx_timing_q, avs_writedata, avs_byteenable);
            end
            `STCT_OFF_PTIMER: begin
               ptimer_q <= ptimer_merged[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_done_q    <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else if (clk_en) begin
         rd_done_q <= rd_en;
         if (rd_en) begin
            case (avs_address)
               `STCT_OFF_CLASS:  avs_readdata <= {16'h0000, class_lookup_q};
               `STCT_OFF_TXTIME: avs_readdata <= tx_timing_q;
               `STCT_OFF_PTIMER: avs_readdata <= {16'h0000, ptimer_q};
               `STCT_OFF_STATUS: avs_readdata <= {16'h0000, conn_cnt_q, rej_cnt_q,
                                                  wait_pend_q, conn_unf_q, rej_unf_q,
                                                  state_q == STCT_LOCKED};
               default:          avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Classification
   assign class_idx = {lock_operation_bit, request_type_bits};
   assign class_sel = sync_request ? 2'h0 : class_lookup_q[{class_idx, 1'b0} +: 2];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         class_code_q    <= 2'h0;
         start_setting_q <= 8'h00;
         retry_setting_q <= 8'h00;
      end else if (clk_en && req_valid) begin
         class_code_q    <= class_sel;
         // Each class uses the same setting for start and retry
         start_setting_q <= tx_timing_q[{class_sel, 3'b000} +: 8];
         retry_setting_q <= tx_timing_q[{class_sel, 3'b000} +: 8];
      end
   end

   // Synchronise the time bases from the clock logic
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rtc_s1_q   <= 16'h0000;
         rtc_s2_q   <= 16'h0000;
         pre_s1_q   <= 6'h00;
         pre_s2_q   <= 6'h00;
         rej_bit_q  <= 1'b0;
         conn_bit_q <= 1'b0;
      end else if (clk_en) begin
         rtc_s1_q   <= rtc_low_word;
         rtc_s2_q   <= rtc_s1_q;
         pre_s1_q   <= prescaler;
         pre_s2_q   <= pre_s1_q;
         rej_bit_q  <= rej_bit;
         conn_bit_q <= pre_s2_q[`STCT_CONN_TICK_BIT];
      end
   end

   assign rej_bit   = rtc_s2_q[ptimer_q[`STCT_PRE_HI:`STCT_PRE_LO]];
   assign rej_tick  = rej_bit && !rej_bit_q;
   assign conn_tick = pre_s2_q[`STCT_CONN_TICK_BIT] && !conn_bit_q;

   assign rej_run = state_q != STCT_IDLE;
   assign conn_unf_now = conn_tick && (conn_cnt_q == 8'h00);

   // Protocol sequence
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= STCT_IDLE;
      end else if (clk_en) begin
         case (state_q)
            STCT_IDLE: begin
               if (first_bid) state_q <= STCT_BIDDING;
            end
            STCT_BIDDING: begin
               if (switch_reject && rej_unf_q) begin
                  state_q <= STCT_IDLE;
               end else if (!switch_reject) begin
                  state_q <= STCT_WAITACK;
               end
            end
            STCT_WAITACK: begin
               if (conn_unf_q || conn_unf_now) begin
                  state_q <= STCT_IDLE;
               end else if (switch_reject) begin
                  state_q <= rej_unf_q ? STCT_IDLE : STCT_BIDDING;
               end else if (msg_ack) begin
                  state_q <= path_locked ? STCT_LOCKED : STCT_IDLE;
               end
            end
            STCT_LOCKED: begin
               if (conn_unf_q || conn_unf_now || !path_locked) state_q <= STCT_IDLE;
            end
            default: state_q <= STCT_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rej_cnt_q <= 4'h0;
         rej_unf_q <= 1'b0;
      end else if (clk_en) begin
         if (!rej_run && !first_bid) begin
            rej_cnt_q <= ptimer_q[`STCT_CNT_HI:`STCT_CNT_LO];
            rej_unf_q <= 1'b0;
         end else if (rej_tick) begin
            rej_cnt_q <= rej_cnt_q - 4'h1;
            if (rej_cnt_q == 4'h0) rej_unf_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         conn_cnt_q <= 8'h00;
         conn_unf_q <= 1'b0;
      end else if (clk_en) begin
         if (first_bid) begin
            conn_cnt_q <= ptimer_q[`STCT_CON_HI:`STCT_CON_LO];
            conn_unf_q <= 1'b0;
         end else if (conn_tick) begin
            conn_cnt_q <= conn_cnt_q - 8'h01;
            if (conn_cnt_q == 8'h00) conn_unf_q <= 1'b1;
         end
      end
   end

   // Error reporting and teardown
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         teardown_q    <= 1'b0;
         error_code_q  <= STCT_NONE;
         error_valid_q <= 1'b0;
         wait_pend_q   <= 1'b0;
      end else if (clk_en) begin
         teardown_q    <= 1'b0;
         error_valid_q <= 1'b0;
         if ((state_q == STCT_BIDDING || state_q == STCT_WAITACK) && switch_reject
             && rej_unf_q && !(state_q == STCT_WAITACK && (conn_unf_q || conn_unf_now))) begin
            teardown_q    <= 1'b1;
            error_code_q  <= STCT_REJECT_TIMEOUT_ERROR;
            error_valid_q <= 1'b1;
         end else if (state_q == STCT_WAITACK && (conn_unf_q || conn_unf_now)) begin
            teardown_q    <= 1'b1;
            error_code_q  <= STCT_CONNECTION_TIMEOUT_ERROR;
            error_valid_q <= 1'b1;
         end else if (state_q == STCT_LOCKED && (conn_unf_q || conn_unf_now)) begin
            teardown_q  <= 1'b1;
            wait_pend_q <= 1'b1;
         end else if (wait_pend_q && req_valid) begin
            error_code_q  <= STCT_WAIT_TIMEOUT_ERROR;
            error_valid_q <= 1'b1;
            wait_pend_q   <= 1'b0;
         end
      end
   end

   property p_sync_class;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && req_valid && sync_request |=> class_code_q == 2'h0
         && start_setting_q == $past(tx_timing_q[7:0]);
   endproperty
   a_sync_class: assert property (p_sync_class) else $error("sync not class 0");

   property p_rej_reload;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == STCT_IDLE && !first_bid |=> !rej_unf_q;
   endproperty
   a_rej_reload: assert property (p_rej_reload) else $error("reject flag not cleared");

   property p_rej_err;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && (state_q == STCT_BIDDING || state_q == STCT_WAITACK) && switch_reject
         && rej_unf_q && !conn_unf_q && !conn_unf_now
         |=> error_valid_q && error_code_q == STCT_REJECT_TIMEOUT_ERROR && teardown_q;
   endproperty
   a_rej_err: assert property (p_rej_err) else $error("reject timeout missed");

   property p_conn_reload;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && first_bid |=> conn_cnt_q == $past(ptimer_q[7:0]) && !conn_unf_q;
   endproperty
   a_conn_reload: assert property (p_conn_reload) else $error("conn reload wrong");

   property p_conn_err;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == STCT_WAITACK && (conn_unf_q || conn_unf_now)
         |=> error_code_q == STCT_CONNECTION_TIMEOUT_ERROR && error_valid_q && teardown_q;
   endproperty
   a_conn_err: assert property (p_conn_err) else $error("conn timeout missed");

   property p_race;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == STCT_WAITACK && msg_ack && conn_unf_now && !switch_reject
         |=> error_code_q == STCT_CONNECTION_TIMEOUT_ERROR && error_valid_q && state_q == STCT_IDLE;
   endproperty
   a_race: assert property (p_race) else $error("race not conn timeout");

   property p_wait_timeout_error;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == STCT_LOCKED && (conn_unf_q || conn_unf_now)
         |=> wait_pend_q && teardown_q && !error_valid_q;
   endproperty
   a_wait_timeout_error: assert property (p_wait_timeout_error) else $error("wait timeout not pending");

   property p_conn_dec;
      @(posedge core_clk) disable iff (!reset_n)
      clk_en && conn_tick && !first_bid |=> conn_cnt_q == $past(conn_cnt_q) - 8'h01;
   endproperty
   a_conn_dec: assert property (p_conn_dec) else $error("conn count wrong");

   c_reject_timeout_error:  cover property (@(posedge core_clk) error_code_q == STCT_REJECT_TIMEOUT_ERROR);
   c_connection_timeout_error: cover property (@(posedge core_clk) error_code_q == STCT_CONNECTION_TIMEOUT_ERROR);
   c_wait_timeout_error: cover property (@(posedge core_clk) error_code_q == STCT_WAIT_TIMEOUT_ERROR);
endmodule : stct_top
`default_nettype wire

// file: dv/stct_partner.sv
// Far-side model: host requests, switch events and free-running time bases
`timescale 1ns/1ns
`default_nettype none
module stct_partner (
   input  wire logic        core_clk,
   output logic      [15:0] rtc_low_word,
   output logic      [5:0]  prescaler,
   output logic             req_valid,
   output logic             lock_operation_bit,
   output logic      [1:0]  request_type_bits,
   output logic             sync_request,
   output logic             first_bid,
   output logic             switch_reject,
   output logic             msg_ack,
   output logic             path_locked
);
   initial begin
      {rtc_low_word, prescaler} = '0;
      {req_valid, lock_operation_bit, request_type_bits, sync_request} = '0;
      {first_bid, switch_reject, msg_ack, path_locked} = '0;
   end
   // Low word steps when the prescaler wraps
   always @(posedge core_clk) begin
      prescaler <= prescaler + 6'h01;
      if (prescaler == 6'h3F)
         rtc_low_word <= rtc_low_word + 16'h0001;
   end
   task automatic request(input logic lk, input logic [1:0] rr, input logic sy);
      @(posedge core_clk);
      req_valid <= 1'b1;
      lock_operation_bit <= lk;
      request_type_bits <= rr;
      sync_request <= sy;
      @(posedge core_clk);
      // Released qualifiers show the inverse, not the last value
      req_valid <= 1'b0;
      sync_request <= ~sy;
      lock_operation_bit <= ~lk;
      request_type_bits <= ~rr;
   endtask : request
   // 0 first bid, 1 reject, 2 acknowledge
   task automatic pulse(input int which);
      @(posedge core_clk);
      first_bid <= (which == 0);
      switch_reject <= (which == 1);
      msg_ack <= (which == 2);
      @(posedge core_clk);
      {first_bid, switch_reject, msg_ack} <= 3'h0;
   endtask : pulse
   task automatic set_lock(input logic v);
      @(posedge core_clk);
      path_locked <= v;
   endtask : set_lock
endmodule : stct_partner
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the class lookup and protocol timers
`timescale 1ns/1ns
`default_nettype none
`include "stct_defines.svh"
module tb;
   import stct_pkg::*;
   logic        core_clk, reset_n, avs_read, avs_write, avs_waitrequest, clk_en;
   logic [3:0]  avs_address, be;
   logic [31:0] avs_writedata, avs_readdata, rd, seed;
   logic [1:0]  avs_response, class_code_q, rr;
   logic [15:0] rtc_low_word;
   logic [5:0]  prescaler;
   logic        req_valid, lk, sy, first_bid, switch_reject, msg_ack, path_locked;
   logic [7:0]  start_setting_q, retry_setting_q;
   logic        teardown_q, error_valid_q;
   logic [2:0]  error_code_q;
   int          fails, check_count, n_td, n_ev, c, k, cls_m, tx_m;

   stct_top dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .rtc_low_word(rtc_low_word), .prescaler(prescaler), .req_valid(req_valid),
      .lock_operation_bit(lk), .request_type_bits(rr), .sync_request(sy),
      .first_bid(first_bid), .switch_reject(switch_reject), .msg_ack(msg_ack),
      .path_locked(path_locked), .class_code_q(class_code_q),
      .start_setting_q(start_setting_q), .retry_setting_q(retry_setting_q),
      .teardown_q(teardown_q), .error_code_q(error_code_q), .error_valid_q(error_valid_q));
   stct_partner far (.core_clk(core_clk), .rtc_low_word(rtc_low_word),
      .prescaler(prescaler), .req_valid(req_valid), .lock_operation_bit(lk),
      .request_type_bits(rr), .sync_request(sy), .first_bid(first_bid),
      .switch_reject(switch_reject), .msg_ack(msg_ack), .path_locked(path_locked));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // Only the watchdog ends a wait that never finishes
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({30'h0, avs_response}, 32'h0);
   endtask : rd_chk
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle
   task automatic wrap_up;
      if (fails == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Counts one-cycle pulses
   always @(posedge core_clk) begin
      if (teardown_q === 1'b1)
         n_td++;
      if (error_valid_q === 1'b1)
         n_ev++;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
   initial begin
      {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {fails, check_count, n_td, n_ev} = '0;
      clk_en = 1'b1;
      be = 4'hF;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      rd_chk(`STCT_OFF_CLASS, `STCT_RST_CLASS);
      rd_chk(`STCT_OFF_TXTIME, `STCT_RST_TXTIME);
      rd_chk(`STCT_OFF_PTIMER, `STCT_RST_PTIMER);
      rd_chk(4'h2, 32'h0);
      seed = lfsr(32'hA0EA);
      // Low four fields hold every class code
      cls_m = {seed[15:8], 8'hE4};
      bus(1'b1, `STCT_OFF_CLASS, cls_m);
      rd_chk(`STCT_OFF_CLASS, cls_m);
      seed = lfsr(lfsr(seed) ^ 32'h5A3C_96E1);
      tx_m = seed;
      bus(1'b1, `STCT_OFF_TXTIME, tx_m);
      rd_chk(`STCT_OFF_TXTIME, tx_m);
      for (c = 0; c < 9; c++) begin
         far.request(c[2], c[1:0], c == 8);
         settle(0);
         k = (c == 8) ? 0 : (cls_m >> (2 * c)) & 3;
         chk(class_code_q, k);
         chk(start_setting_q, (tx_m >> (8 * k)) & 255);
         chk(retry_setting_q, (tx_m >> (8 * k)) & 255);
      end
      // Writes stall while disabled; only the low byte lane is enabled
      clk_en <= 1'b0;
      be <= 4'h1;
      fork
         bus(1'b1, `STCT_OFF_CLASS, 32'h0000_5A00 | (seed & 32'hFF));
         begin
            repeat (4) @(posedge core_clk);
            chk(avs_waitrequest, 1'b1);
            clk_en <= 1'b1;
         end
      join
      be <= 4'hF;
      rd_chk(`STCT_OFF_CLASS, (cls_m & 32'hFF00) | (seed & 32'hFF));
      bus(1'b1, `STCT_OFF_PTIMER, 32'h10FF);
      settle(4);
      bus(1'b0, `STCT_OFF_STATUS, 32'h0);
      chk({28'h0, rd[7:4]}, 32'h1);
      far.pulse(0);
      far.pulse(1);
      settle(3);
      chk(n_ev, 0);
      far.pulse(0);
      settle(500);
      far.pulse(1);
      settle(3);
      chk(error_code_q, STCT_REJECT_TIMEOUT_ERROR);
      chk(n_ev, 1);
      chk(n_td, 1);
      bus(1'b1, `STCT_OFF_PTIMER, 32'hFF02);
      far.pulse(0);
      settle(100);
      chk(n_td, 1);
      settle(200);
      chk(error_code_q, STCT_CONNECTION_TIMEOUT_ERROR);
      chk(n_td, 2);
      chk(n_ev, 2);
      far.set_lock(1'b1);
      far.pulse(0);
      far.pulse(2);
      settle(300);
      chk(n_td, 3);
      chk(n_ev, 2);
      far.set_lock(1'b0);
      far.request(1'b0, 2'h0, 1'b0);
      settle(3);
      chk(error_code_q, STCT_WAIT_TIMEOUT_ERROR);
      chk(n_ev, 3);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
